//--- pkg/acd_consts.vh
// Register offsets, field positions, reset values and timing counts for the clock slice.
`ifndef ACD_CONSTS_VH
`define ACD_CONSTS_VH

// ************************************************************
// Register offsets.
// ************************************************************
`define ACD_OFS_ASYNC_SRC_CFG 16'h0112
`define ACD_OFS_RATE_SEL_ONE 16'h0113
`define ACD_OFS_RATE_SEL_TWO 16'h0114
`define ACD_OFS_RATE_STS_ONE 16'h011B
`define ACD_OFS_RATE_STS_TWO 16'h011C
`define ACD_OFS_MAIN_OUT 16'h0149
`define ACD_OFS_ASYNC_OUT 16'h014A
`define ACD_OFS_EST_CTRL 16'h0152
`define ACD_OFS_CAND_A 16'h0153
`define ACD_OFS_CAND_B 16'h0154
`define ACD_OFS_CAND_C 16'h0155
`define ACD_OFS_CAND_D 16'h0156
`define ACD_OFS_PAD_ONE 16'h0C20
`define ACD_OFS_PAD_TWO 16'h0C21

// ************************************************************
// Field positions.
// ************************************************************
`define ACD_SRC_LSB 0
`define ACD_DOM_ENA_BIT 6
`define ACD_DOM_FREQ_LSB 8
`define ACD_OUT_ENA_BIT 15
`define ACD_OUT_DIV_LSB 3
`define ACD_OUT_SEL_LSB 0
`define ACD_EST_ENA_BIT 0
`define ACD_EST_SRC_LSB 1
`define ACD_EST_TRIG_BIT 4
`define ACD_PD_TWO_BIT 13
`define ACD_PD_ONE_BIT 12

// ************************************************************
// Reset values and codes.
// ************************************************************
`define ACD_RST_ASYNC_SRC 4'h5
`define ACD_RST_DOM_FREQ 3'h3
`define ACD_RST_RATE_SEL 5'h11
`define ACD_RATE_NONE 5'h00
`define ACD_FAMILY_44K 2'h1

// ************************************************************
// Timing: system clock and estimator tolerance.
// ************************************************************
`define ACD_SYS_CLK_HZ 20000000
`define ACD_EST_TOL_SHIFT 6
`define ACD_EST_CNT_W 14

`endif

//--- hdl/acd_clk_div.v
// Clock output divider: toggles its output after a programmed number of source ticks.
`timescale 1ns/100ps
module acd_clk_div #(
	parameter RW = 8
) (
	input wire clk_sys_i,
	input wire rstn_i,
	input wire en_i,
	input wire tick_i,
	input wire [RW-1:0] ratio_i,
	output reg clk_o
);
	reg [RW-1:0] cnt_q;

	// A disabled output sits low with a cleared count, so re-enabling starts a whole phase.
	always @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_q <= {RW{1'b0}};
			clk_o <= 1'b0;
		end else if (!en_i) begin
			cnt_q <= {RW{1'b0}};
			clk_o <= 1'b0;
		end else if (tick_i) begin
			if ((cnt_q + 1'b1) >= ratio_i) begin
				cnt_q <= {RW{1'b0}};
				clk_o <= ~clk_o;
			end else begin
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end
endmodule

//--- hdl/acd_rate_est.v
// Sample-rate estimator: times frame clock periods and matches them against candidates.
`timescale 1ns/100ps
`include "acd_consts.vh"
module acd_rate_est (
	input wire clk_sys_i,
	input wire rstn_i,
	input wire en_i,
	input wire trig_all_i,
	input wire frame_i,
	input wire [19:0] cand_i,
	output reg [4:0] rate_o,
	output reg locked_o,
	output reg seq_trig_o
);
	localparam CW = `ACD_EST_CNT_W;
	localparam [CW-1:0] CMAX = {CW{1'b1}};

	reg [CW-1:0] cnt_q;
	reg frame_q;
	reg seen_q;
	reg first_q;
	reg hit;
	reg [4:0] hit_code;
	integer i;
	wire [CW-1:0] span_len;

	// Cycles from one rising frame edge to the next, the closing edge counted.
	assign span_len = cnt_q + 1'b1;

	// Nominal frame period in system clock cycles for each rate code.
	function [CW-1:0] nom_period;
		input [4:0] code;
		integer per;
		begin
			case (code)
				5'h01: per = `ACD_SYS_CLK_HZ / 12000;
				5'h02: per = `ACD_SYS_CLK_HZ / 24000;
				5'h03: per = `ACD_SYS_CLK_HZ / 48000;
				5'h04: per = `ACD_SYS_CLK_HZ / 96000;
				5'h05: per = `ACD_SYS_CLK_HZ / 192000;
				5'h09: per = (`ACD_SYS_CLK_HZ * 10) / 110250;
				5'h0A: per = (`ACD_SYS_CLK_HZ * 10) / 220500;
				5'h0B: per = (`ACD_SYS_CLK_HZ * 10) / 441000;
				5'h0C: per = (`ACD_SYS_CLK_HZ * 10) / 882000;
				5'h0D: per = (`ACD_SYS_CLK_HZ * 10) / 1764000;
				5'h10: per = `ACD_SYS_CLK_HZ / 4000;
				5'h11: per = `ACD_SYS_CLK_HZ / 8000;
				5'h12: per = `ACD_SYS_CLK_HZ / 16000;
				5'h13: per = `ACD_SYS_CLK_HZ / 32000;
				default: per = 0;
			endcase
			// Every nominal period fits the counter, so the upper bits are dropped on purpose.
			nom_period = per[CW-1:0];
		end
	endfunction

	// Picks the first enabled candidate whose nominal period is within tolerance.
	always @* begin
		hit = 1'b0;
		hit_code = `ACD_RATE_NONE;
		for (i = 0; i < 4; i = i + 1) begin
			if (!hit && nom_period(cand_i[i*5 +: 5]) != {CW{1'b0}} &&
				span_len + (nom_period(cand_i[i*5 +: 5]) >> `ACD_EST_TOL_SHIFT) >=
				nom_period(cand_i[i*5 +: 5]) &&
				span_len <= nom_period(cand_i[i*5 +: 5]) +
				(nom_period(cand_i[i*5 +: 5]) >> `ACD_EST_TOL_SHIFT)) begin
				hit = 1'b1;
				hit_code = cand_i[i*5 +: 5];
			end
		end
	end

	// Rising frame edges close a period; a matching period updates the detected rate.
	always @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_q <= {CW{1'b0}};
			frame_q <= 1'b0;
			seen_q <= 1'b0;
			first_q <= 1'b1;
			rate_o <= `ACD_RATE_NONE;
			locked_o <= 1'b0;
			seq_trig_o <= 1'b0;
		end else begin
			frame_q <= frame_i;
			seq_trig_o <= 1'b0;
			if (!en_i) begin
				cnt_q <= {CW{1'b0}};
				seen_q <= 1'b0;
				first_q <= 1'b1;
				locked_o <= 1'b0;
			end else if (frame_i && !frame_q) begin
				cnt_q <= {CW{1'b0}};
				seen_q <= 1'b1;
				if (seen_q && hit) begin
					locked_o <= 1'b1;
					if (hit_code != rate_o || !locked_o) begin
						rate_o <= hit_code;
						first_q <= 1'b0;
						seq_trig_o <= trig_all_i | ~first_q;
					end
				end else if (seen_q) begin
					locked_o <= 1'b0;
				end
			end else if (cnt_q != CMAX) begin
				cnt_q <= cnt_q + 1'b1;
			end else begin
				locked_o <= 1'b0;
			end
		end
	end
endmodule

//--- hdl/acd_top.v
// Async clock control: source and rate registers, clock outputs, rate estimator, pad pulls.
//
// Notes on behaviour
// - Async source code picks pin, loop or bit clock.
// - Rate fields use the common 5-bit code.
// - Two async rate selects, both reset to 8 kHz.
// - Read-only rate status copies, reset zero.
// - Output enable bits at 15, reset off.
// - Main output source frequency picks four ratings.
// - Async output uses same codes and family.
// - Estimator runs only while its enable is set.
// - Estimator watches one of six frame clocks.
// - Trigger bit decides sequencer launch on first detect.
// - Four candidate rates, reset to none.
// - Pad bits enable master clock pull-downs.
// - Unlocked domain drops or repeats samples.
// - Domain frequency field, 3 bits, reset 011.
`timescale 1ns/100ps
`include "acd_consts.vh"
module acd_top (
	input wire clk_sys_i,
	input wire rstn_i,
	input wire [15:0] reg_addr_i,
	input wire [15:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	output reg [15:0] reg_rdata_o,
	output reg reg_rvalid_o,
	input wire master_clock_in_one_i,
	input wire master_clock_in_two_i,
	input wire locked_loop_one_i,
	input wire locked_loop_two_i,
	input wire iface_one_bit_clock_i,
	input wire iface_two_bit_clock_i,
	input wire iface_three_bit_clock_i,
	input wire iface_one_rx_frame_clock_i,
	input wire iface_one_tx_frame_clock_i,
	input wire iface_two_rx_frame_clock_i,
	input wire iface_two_tx_frame_clock_i,
	input wire iface_three_rx_frame_clock_i,
	input wire iface_three_tx_frame_clock_i,
	output reg async_domain_clock_o,
	output reg main_clock_output_o,
	output reg async_clock_output_o,
	output reg master_in_one_pulldown_o,
	output reg master_in_two_pulldown_o,
	output reg [4:0] detected_rate_o,
	output reg rate_locked_o,
	output reg sequencer_trigger_o
);
	// ************************************************************
	// Input synchronisers.
	// ************************************************************
	localparam NIN = 13;

	wire [NIN-1:0] pins_raw;
	reg [NIN-1:0] sync1_q;
	reg [NIN-1:0] sync2_q;

	assign pins_raw = {iface_three_tx_frame_clock_i, iface_three_rx_frame_clock_i,
		iface_two_tx_frame_clock_i, iface_two_rx_frame_clock_i,
		iface_one_tx_frame_clock_i, iface_one_rx_frame_clock_i,
		iface_three_bit_clock_i, iface_two_bit_clock_i, iface_one_bit_clock_i,
		locked_loop_two_i, locked_loop_one_i,
		master_clock_in_two_i, master_clock_in_one_i};

	// Two flops per pin; each edge detector downstream keeps its own history flop.
	always @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sync1_q <= {NIN{1'b0}};
			sync2_q <= {NIN{1'b0}};
		end else begin
			sync1_q <= pins_raw;
			sync2_q <= sync1_q;
		end
	end

	// ************************************************************
	// Registers.
	// ************************************************************
	reg [3:0] async_source_select_q;
	reg async_domain_enable_q;
	reg [2:0] async_domain_frequency_q;
	reg [4:0] rate_sel_one_q;
	reg [4:0] rate_sel_two_q;
	reg [4:0] async_rate_one_status_q;
	reg [4:0] async_rate_two_status_q;
	reg main_output_enable_q;
	reg [4:0] main_output_divider_q;
	reg [2:0] main_output_source_freq_q;
	reg async_output_enable_q;
	reg [4:0] async_output_divider_q;
	reg [2:0] async_output_source_freq_q;
	reg estimator_enable_q;
	reg [2:0] estimator_frame_source_q;
	reg sequencer_first_detect_trigger_q;
	reg [4:0] cand_a_q;
	reg [4:0] cand_b_q;
	reg [4:0] cand_c_q;
	reg [4:0] cand_d_q;
	reg pd_two_q;
	reg pd_one_q;

	// Writes store the documented fields; status offsets ignore writes.
	always @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			async_source_select_q <= `ACD_RST_ASYNC_SRC;
			async_domain_enable_q <= 1'b0;
			async_domain_frequency_q <= `ACD_RST_DOM_FREQ;
			rate_sel_one_q <= `ACD_RST_RATE_SEL;
			rate_sel_two_q <= `ACD_RST_RATE_SEL;
			main_output_enable_q <= 1'b0;
			main_output_divider_q <= 5'h00;
			main_output_source_freq_q <= 3'h0;
			async_output_enable_q <= 1'b0;
			async_output_divider_q <= 5'h00;
			async_output_source_freq_q <= 3'h0;
			estimator_enable_q <= 1'b0;
			estimator_frame_source_q <= 3'h0;
			sequencer_first_detect_trigger_q <= 1'b0;
			cand_a_q <= `ACD_RATE_NONE;
			cand_b_q <= `ACD_RATE_NONE;
			cand_c_q <= `ACD_RATE_NONE;
			cand_d_q <= `ACD_RATE_NONE;
			pd_two_q <= 1'b0;
			pd_one_q <= 1'b0;
		end else if (reg_wr_i) begin
			case (reg_addr_i)
				`ACD_OFS_ASYNC_SRC_CFG: begin
					async_source_select_q <= reg_wdata_i[`ACD_SRC_LSB +: 4];
					async_domain_enable_q <= reg_wdata_i[`ACD_DOM_ENA_BIT];
					async_domain_frequency_q <= reg_wdata_i[`ACD_DOM_FREQ_LSB +: 3];
				end
				`ACD_OFS_RATE_SEL_ONE: begin
					rate_sel_one_q <= reg_wdata_i[4:0];
				end
				`ACD_OFS_RATE_SEL_TWO: begin
					rate_sel_two_q <= reg_wdata_i[4:0];
				end
				`ACD_OFS_MAIN_OUT: begin
					main_output_enable_q <= reg_wdata_i[`ACD_OUT_ENA_BIT];
					main_output_divider_q <= reg_wdata_i[`ACD_OUT_DIV_LSB +: 5];
					main_output_source_freq_q <= reg_wdata_i[`ACD_OUT_SEL_LSB +: 3];
				end
				`ACD_OFS_ASYNC_OUT: begin
					async_output_enable_q <= reg_wdata_i[`ACD_OUT_ENA_BIT];
					async_output_divider_q <= reg_wdata_i[`ACD_OUT_DIV_LSB +: 5];
					async_output_source_freq_q <= reg_wdata_i[`ACD_OUT_SEL_LSB +: 3];
				end
				`ACD_OFS_EST_CTRL: begin
					estimator_enable_q <= reg_wdata_i[`ACD_EST_ENA_BIT];
					estimator_frame_source_q <= reg_wdata_i[`ACD_EST_SRC_LSB +: 3];
					sequencer_first_detect_trigger_q <= reg_wdata_i[`ACD_EST_TRIG_BIT];
				end
				`ACD_OFS_CAND_A: begin
					cand_a_q <= reg_wdata_i[4:0];
				end
				`ACD_OFS_CAND_B: begin
					cand_b_q <= reg_wdata_i[4:0];
				end
				`ACD_OFS_CAND_C: begin
					cand_c_q <= reg_wdata_i[4:0];
				end
				`ACD_OFS_CAND_D: begin
					cand_d_q <= reg_wdata_i[4:0];
				end
				`ACD_OFS_PAD_ONE: begin
					pd_two_q <= reg_wdata_i[`ACD_PD_TWO_BIT];
				end
				`ACD_OFS_PAD_TWO: begin
					pd_one_q <= reg_wdata_i[`ACD_PD_ONE_BIT];
				end
				default: begin
					pd_one_q <= pd_one_q;
				end
			endcase
		end
	end

	// Status shows the rate in force while the domain enable is set, none otherwise.
	always @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			async_rate_one_status_q <= `ACD_RATE_NONE;
			async_rate_two_status_q <= `ACD_RATE_NONE;
		end else begin
			async_rate_one_status_q <= async_domain_enable_q ? rate_sel_one_q : `ACD_RATE_NONE;
			async_rate_two_status_q <= async_domain_enable_q ? rate_sel_two_q : `ACD_RATE_NONE;
		end
	end

	// Reads answer one cycle later; unmapped offsets read as zero.
	always @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			reg_rdata_o <= 16'h0000;
			reg_rvalid_o <= 1'b0;
		end else begin
			reg_rvalid_o <= reg_rd_i;
			reg_rdata_o <= 16'h0000;
			if (reg_rd_i) begin
				case (reg_addr_i)
					`ACD_OFS_ASYNC_SRC_CFG: reg_rdata_o <= {5'h00, async_domain_frequency_q,
						1'b0, async_domain_enable_q, 2'h0, async_source_select_q};
					`ACD_OFS_RATE_SEL_ONE: reg_rdata_o <= {11'h000, rate_sel_one_q};
					`ACD_OFS_RATE_SEL_TWO: reg_rdata_o <= {11'h000, rate_sel_two_q};
					`ACD_OFS_RATE_STS_ONE: reg_rdata_o <= {11'h000, async_rate_one_status_q};
					`ACD_OFS_RATE_STS_TWO: reg_rdata_o <= {11'h000, async_rate_two_status_q};
					`ACD_OFS_MAIN_OUT: reg_rdata_o <= {main_output_enable_q, 7'h00,
						main_output_divider_q, main_output_source_freq_q};
					`ACD_OFS_ASYNC_OUT: reg_rdata_o <= {async_output_enable_q, 7'h00,
						async_output_divider_q, async_output_source_freq_q};
					`ACD_OFS_EST_CTRL: reg_rdata_o <= {11'h000, sequencer_first_detect_trigger_q,
						estimator_frame_source_q, estimator_enable_q};
					`ACD_OFS_CAND_A: reg_rdata_o <= {11'h000, cand_a_q};
					`ACD_OFS_CAND_B: reg_rdata_o <= {11'h000, cand_b_q};
					`ACD_OFS_CAND_C: reg_rdata_o <= {11'h000, cand_c_q};
					`ACD_OFS_CAND_D: reg_rdata_o <= {11'h000, cand_d_q};
					`ACD_OFS_PAD_ONE: reg_rdata_o <= {2'h0, pd_two_q, 13'h0000};
					`ACD_OFS_PAD_TWO: reg_rdata_o <= {3'h0, pd_one_q, 12'h000};
					default: reg_rdata_o <= 16'h0000;
				endcase
			end
		end
	end

	// ************************************************************
	// Async domain source selection.
	// ************************************************************
	reg src_sel;
	reg src_ok;

	// Reserved codes select nothing and the domain clock stays low.
	always @* begin
		src_ok = 1'b1;
		case (async_source_select_q)
			4'h0: src_sel = sync2_q[0];
			4'h1: src_sel = sync2_q[1];
			4'h4: src_sel = sync2_q[2];
			4'h5: src_sel = sync2_q[3];
			4'h8: src_sel = sync2_q[4];
			4'h9: src_sel = sync2_q[5];
			4'hA: src_sel = sync2_q[6];
			default: begin
				src_sel = 1'b0;
				src_ok = 1'b0;
			end
		endcase
	end

	reg src_prev_q;
	wire async_tick;

	// The domain clock follows the source only while enabled; software enables it last.
	always @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			async_domain_clock_o <= 1'b0;
			src_prev_q <= 1'b0;
		end else begin
			src_prev_q <= src_sel;
			async_domain_clock_o <= src_sel & src_ok & async_domain_enable_q;
		end
	end

	assign async_tick = (src_sel != src_prev_q) & src_ok & async_domain_enable_q;

	// ************************************************************
	// Clock outputs.
	// ************************************************************
	// Divider code to ratio; codes 0 and 1 both divide by one.
	function [4:0] div_ratio;
		input [4:0] code;
		begin
			div_ratio = (code < 5'h02) ? 5'h01 : code;
		end
	endfunction

	// Prescale from the domain rating down to the selected output rating.
	function [3:0] prescale;
		input [2:0] dom;
		input [2:0] sel;
		begin
			if (sel > 3'h3 || sel > dom) begin
				prescale = 4'h1;
			end else begin
				prescale = 4'h1 << (dom - sel);
			end
		end
	endfunction

	wire [7:0] main_ratio;
	wire [7:0] async_ratio;
	wire main_div_clk;
	wire async_div_clk;

	// The main output treats the system clock as the top rating, code 011.
	assign main_ratio = {3'h0, div_ratio(main_output_divider_q)} *
		{4'h0, prescale(3'h3, main_output_source_freq_q)};
	assign async_ratio = {3'h0, div_ratio(async_output_divider_q)} *
		{4'h0, prescale(async_domain_frequency_q, async_output_source_freq_q)};

	acd_clk_div #(.RW(8)) u_main_div (
		.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i),
		.en_i(main_output_enable_q),
		.tick_i(1'b1),
		.ratio_i(main_ratio),
		.clk_o(main_div_clk)
	);

	acd_clk_div #(.RW(8)) u_async_div (
		.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i),
		.en_i(async_output_enable_q),
		.tick_i(async_tick),
		.ratio_i(async_ratio),
		.clk_o(async_div_clk)
	);

	// ************************************************************
	// Rate estimator.
	// ************************************************************
	reg frame_sel;

	// Reserved source codes watch a quiet line, so nothing is detected.
	always @* begin
		case (estimator_frame_source_q)
			3'h0: frame_sel = sync2_q[7];
			3'h1: frame_sel = sync2_q[8];
			3'h2: frame_sel = sync2_q[9];
			3'h3: frame_sel = sync2_q[10];
			3'h4: frame_sel = sync2_q[11];
			3'h5: frame_sel = sync2_q[12];
			default: frame_sel = 1'b0;
		endcase
	end

	wire [4:0] est_rate;
	wire est_locked;
	wire est_trig;

	acd_rate_est u_est (
		.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i),
		.en_i(estimator_enable_q),
		.trig_all_i(sequencer_first_detect_trigger_q),
		.frame_i(frame_sel),
		.cand_i({cand_d_q, cand_c_q, cand_b_q, cand_a_q}),
		.rate_o(est_rate),
		.locked_o(est_locked),
		.seq_trig_o(est_trig)
	);

	// ************************************************************
	// Registered outputs.
	// ************************************************************
	// All pin-facing results leave through flops.
	always @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			main_clock_output_o <= 1'b0;
			async_clock_output_o <= 1'b0;
			master_in_one_pulldown_o <= 1'b0;
			master_in_two_pulldown_o <= 1'b0;
			detected_rate_o <= `ACD_RATE_NONE;
			rate_locked_o <= 1'b0;
			sequencer_trigger_o <= 1'b0;
		end else begin
			main_clock_output_o <= main_div_clk;
			async_clock_output_o <= async_div_clk;
			master_in_one_pulldown_o <= pd_one_q;
			master_in_two_pulldown_o <= pd_two_q;
			detected_rate_o <= est_rate;
			rate_locked_o <= est_locked;
			sequencer_trigger_o <= est_trig;
		end
	end
endmodule

//--- verif/acd_checker.sv
// Concurrent assertions on the ports of the async clock control slice.
`timescale 1ns/100ps
module acd_checker (
	input wire clk_sys_i,
	input wire rstn_i,
	input wire [15:0] reg_addr_i,
	input wire [15:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	input wire [15:0] reg_rdata_o,
	input wire reg_rvalid_o,
	input wire async_domain_clock_o,
	input wire main_clock_output_o,
	input wire async_clock_output_o,
	input wire master_in_one_pulldown_o,
	input wire master_in_two_pulldown_o,
	input wire [4:0] detected_rate_o,
	input wire rate_locked_o,
	input wire sequencer_trigger_o
);
	// ********
	// Shadow copies of the enables and the domain source.
	// ********
	reg [4:0] dom_q;
	reg [2:0] en_q;
	wire dom_off = !dom_q[4] || !(dom_q[3:0] inside {4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'hA});
	wire wr_p1 = reg_wr_i && reg_addr_i == 16'h0C20;
	wire wr_p2 = reg_wr_i && reg_addr_i == 16'h0C21;
	// Follow register writes so that the gates can be checked against the outputs.
	always @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			dom_q <= 5'h05;
			en_q <= 3'h0;
		end else if (reg_wr_i) begin
			case (reg_addr_i)
				16'h0112: dom_q <= {reg_wdata_i[6], reg_wdata_i[3:0]};
				16'h0149: en_q[0] <= reg_wdata_i[15];
				16'h014A: en_q[1] <= reg_wdata_i[15];
				16'h0152: en_q[2] <= reg_wdata_i[0];
				default: ;
			endcase
		end
	end
	// ********
	// Assertions.
	// ********
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rstn_i);
	chk_rd_answer: assert property (reg_rd_i |=> reg_rvalid_o)
		else $error("read got no answer");
	chk_dom_gate: assert property (dom_off [*6] |-> !async_domain_clock_o)
		else $error("domain clock moves while gated");
	chk_main_off: assert property ((!en_q[0]) [*4] |-> !main_clock_output_o)
		else $error("main output not low while off");
	chk_async_off: assert property ((!en_q[1]) [*4] |-> !async_clock_output_o)
		else $error("async output not low while off");
	chk_est_off: assert property ((!en_q[2]) [*4] |-> !rate_locked_o && !sequencer_trigger_o)
		else $error("estimator active while off");
	chk_trig_pulse: assert property (sequencer_trigger_o |=> !sequencer_trigger_o)
		else $error("trigger longer than one cycle");
	chk_trig_lock: assert property (sequencer_trigger_o |-> ##[0:1] rate_locked_o)
		else $error("trigger without a match");
	chk_lock_rate: assert property (rate_locked_o |-> detected_rate_o != 5'h00)
		else $error("locked on an empty code");
	chk_pad_two: assert property (wr_p1 ##1 !wr_p1 |=>
		master_in_two_pulldown_o == $past(reg_wdata_i[13], 2)) else $error("pull-down two wrong");
	chk_pad_one: assert property (wr_p2 ##1 !wr_p2 |=>
		master_in_one_pulldown_o == $past(reg_wdata_i[12], 2)) else $error("pull-down one wrong");
endmodule

bind acd_top acd_checker i_chk (.*);

//--- verif/acd_clk_src_model.sv
// Far-side clock sources: master clocks, loops, bit clocks and frame clocks.
`timescale 1ns/100ps
module acd_clk_src_model (
	input int half_ns_i,
	input logic [2:0] frame_sel_i,
	output logic [6:0] src_clk_o,
	output wire [5:0] frame_o
);
	logic fr = 1'b0;
	// Each source runs on its own half period, offset so it never meets a system clock edge.
	for (genvar g = 0; g < 7; g++) begin : g_src
		initial begin
			src_clk_o[g] = 1'b0;
			#7;
			forever #(500 + 50 * g) src_clk_o[g] = ~src_clk_o[g];
		end
	end
	// The chosen frame clock runs from the same time base; the others stand low.
	// A small start offset keeps every frame edge off the system clock edges.
	initial begin
		#3;
		forever #(half_ns_i) fr = ~fr;
	end
	assign frame_o = frame_sel_i < 3'h6 ? (6'h01 << frame_sel_i) & {6{fr}} : 6'h00;
endmodule

//--- verif/tb_top.sv
// Self-checking testbench for the async clock control slice.
`timescale 1ns/100ps
module tb_top;
	logic clk_sys_i = 1'b0;
	logic rstn_i = 1'b0;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [15:0] reg_addr_i = 16'h0;
	logic [15:0] reg_wdata_i = 16'h0;
	wire [15:0] reg_rdata_o;
	wire [4:0] detected_rate_o;
	wire reg_rvalid_o, async_domain_clock_o, main_clock_output_o, async_clock_output_o;
	wire master_in_one_pulldown_o, master_in_two_pulldown_o, rate_locked_o, sequencer_trigger_o;
	wire master_clock_in_one_i, master_clock_in_two_i, locked_loop_one_i, locked_loop_two_i;
	wire iface_one_bit_clock_i, iface_two_bit_clock_i, iface_three_bit_clock_i;
	wire iface_one_rx_frame_clock_i, iface_one_tx_frame_clock_i, iface_two_rx_frame_clock_i;
	wire iface_two_tx_frame_clock_i, iface_three_rx_frame_clock_i, iface_three_tx_frame_clock_i;
	wire [6:0] src_clk;
	wire [5:0] frame;
	int half_ns = 10425;
	logic [2:0] frame_sel = 3'h7;
	int failures = 0;
	int total_checks = 0;
	int trig_cnt = 0;
	int n;
	int k;
	logic [15:0] rdv;
	logic [15:0] ofs [14] = '{16'h112, 16'h113, 16'h114, 16'h11B, 16'h11C, 16'h149, 16'h14A,
		16'h152, 16'h153, 16'h154, 16'h155, 16'h156, 16'hC20, 16'hC21};
	logic [15:0] rst [14] = '{0: 16'h0305, 1: 16'h0011, 2: 16'h0011, default: 16'h0};
	logic [15:0] msk [14] = '{0: 16'h074F, 3: 16'h0, 4: 16'h0, 5: 16'h80FF, 6: 16'h80FF,
		12: 16'h2000, 13: 16'h1000, default: 16'h001F};
	logic [4:0] dv [5] = '{5'h00, 5'h01, 5'h02, 5'h1F, 5'h03};
	logic [2:0] sl [5] = '{3'h3, 3'h3, 3'h0, 3'h3, 3'h1};
	// Source clocks and frame clocks from the far-side model fan out to the pins.
	assign {iface_three_bit_clock_i, iface_two_bit_clock_i, iface_one_bit_clock_i, locked_loop_two_i,
		locked_loop_one_i, master_clock_in_two_i, master_clock_in_one_i} = src_clk;
	assign {iface_three_tx_frame_clock_i, iface_three_rx_frame_clock_i, iface_two_tx_frame_clock_i,
		iface_two_rx_frame_clock_i, iface_one_tx_frame_clock_i, iface_one_rx_frame_clock_i} = frame;
	acd_top i_dut (.*);
	acd_clk_src_model i_src (.half_ns_i(half_ns), .frame_sel_i(frame_sel), .src_clk_o(src_clk),
		.frame_o(frame));
	// Clock and a count of sequencer launches.
	always #25 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) if (sequencer_trigger_o === 1'b1) trig_cnt++;
	// ********
	// Bus, compare and measurement tasks.
	// ********
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rchk(input logic [15:0] a, input logic [15:0] e);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_rd_i <= 1'b0;
		#1;
		chk(reg_rvalid_o, 1'b1);
		chk(reg_rdata_o, e);
	endtask
	function automatic logic pick(input int w);
		return w == 0 ? main_clock_output_o : w == 1 ? async_clock_output_o : async_domain_clock_o;
	endfunction
	// Counts level changes of one output over a fixed window.
	task automatic toggles(input int w, input int cyc, output int cnt);
		logic p;
		cnt = 0;
		p = pick(w);
		repeat (cyc) begin
			@(posedge clk_sys_i);
			#1;
			if (pick(w) !== p) cnt++;
			p = pick(w);
		end
	endtask
	// Waits for one edge, then measures the following half period in cycles.
	task automatic half(input int w, output int len);
		logic p;
		for (int i = 0; i < 2; i++) begin
			p = pick(w);
			len = 0;
			while (pick(w) === p && len < 400) begin
				@(posedge clk_sys_i);
				#1;
				len++;
			end
		end
		if (len == 400) begin
			chk(1'b0, 1'b1);
			wrap_up;
		end
	endtask
	task automatic est(input logic [2:0] s, input int hn, input logic t);
		wr(16'h152, 16'h0000);
		repeat (4) @(posedge clk_sys_i);
		frame_sel = s;
		half_ns = hn;
		trig_cnt = 0;
		wr(16'h152, {11'h000, t, s, 1'b1});
	endtask
	task automatic wait_lock(input logic [4:0] r);
		int i;
		for (i = 0; i < 9000; i++) begin
			@(posedge clk_sys_i);
			if (rate_locked_o === 1'b1 && detected_rate_o === r) break;
		end
		if (i == 9000) begin
			chk(1'b0, 1'b1);
			wrap_up;
		end
		repeat (3) @(posedge clk_sys_i);
		#1;
	endtask
	task automatic wrap_up;
		$display("checks %0d, mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// ********
	// Test sequence.
	// ********
	initial begin
		repeat (8) @(posedge clk_sys_i);
		rstn_i <= 1'b1;
		foreach (ofs[i]) rchk(ofs[i], rst[i]);
		rchk(16'h200, 16'h0000);
		$display("test reset values done");
		foreach (ofs[i]) begin
			wr(ofs[i], 16'hFFFF);
			rchk(ofs[i], msk[i]);
			wr(ofs[i], rst[i]);
		end
		wr(16'hC21, 16'h1000);
		repeat (3) @(posedge clk_sys_i);
		#1;
		chk({master_in_one_pulldown_o, master_in_two_pulldown_o}, 2'b10);
		wr(16'hC21, 16'h0000);
		wr(16'hC20, 16'h2000);
		repeat (3) @(posedge clk_sys_i);
		#1;
		chk({master_in_one_pulldown_o, master_in_two_pulldown_o}, 2'b01);
		wr(16'h113, 16'h0003);
		wr(16'h114, 16'h000B);
		wr(16'h112, 16'h0345);
		rchk(16'h11B, 16'h0003);
		rchk(16'h11C, 16'h000B);
		$display("test register access done");
		for (logic [4:0] c = 5'h00; c < 5'h10; c++) begin
			wr(16'h112, {11'h018, c});
			wr(16'h112, {11'h01A, c});
			repeat (8) @(posedge clk_sys_i);
			toggles(2, 80, n);
			chk(n != 0, c inside {0, 1, 4, 5, 8, 9, 10});
		end
		wr(16'h112, 16'h0340);
		foreach (dv[i]) begin
			wr(16'h149, {8'h80, dv[i], sl[i]});
			wr(16'h14A, {8'h80, dv[i], sl[i]});
			k = (dv[i] < 5'h02 ? 1 : int'(dv[i])) << (3 - sl[i]);
			half(0, n);
			chk(16'(n), 16'(k));
			half(1, n);
			chk(16'(n), 16'(10 * k));
		end
		wr(16'h149, 16'h0000);
		wr(16'h14A, 16'h0000);
		repeat (4) @(posedge clk_sys_i);
		toggles(0, 40, n);
		chk({n[14:0], main_clock_output_o}, 16'h0000);
		toggles(1, 40, n);
		chk({n[14:0], async_clock_output_o}, 16'h0000);
		$display("test clock outputs done");
		wr(16'h153, 16'h0003);
		wr(16'h154, 16'h0011);
		for (int s = 0; s < 6; s++) begin
			est(s[2:0], 10425, s[0]);
			wait_lock(5'h03);
			chk(16'(trig_cnt), 16'(s[0]));
		end
		est(3'h0, 10425, 1'b0);
		wait_lock(5'h03);
		half_ns = 31250;
		repeat (5000) @(posedge clk_sys_i);
		chk(rate_locked_o, 1'b0);
		half_ns = 62500;
		wait_lock(5'h11);
		chk(16'(trig_cnt), 16'h0001);
		wr(16'h152, 16'h0000);
		repeat (4) @(posedge clk_sys_i);
		chk(rate_locked_o, 1'b0);
		$display("test estimator done");
		wrap_up;
	end
endmodule
